/* File: hw/bsd_pkg.sv */
// Package holding register map, field positions and mode codes for the bus shutdown block.
package bsd_pkg;
  // ==========================================================================
  // Register byte addresses.
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_RESET = 12'h004;
  localparam logic [11:0] ADDR_BIT_WORD = 12'h078;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h080;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h084;
  localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h088;
  // ==========================================================================
  // Field positions.
  localparam int CFG_INHIBIT_TX_A = 15;
  localparam int CFG_INHIBIT_TX_B = 14;
  localparam int CFG_TX_ONLY = 13;
  localparam int CFG_AUTO_DISABLE = 4;
  localparam int RST_TERMINAL = 10;
  localparam int BIT_TX_SHUT_B = 15;
  localparam int BIT_RX_SHUT_B = 14;
  localparam int BIT_TX_SHUT_A = 13;
  localparam int BIT_RX_SHUT_A = 12;
  // ==========================================================================
  // Reset values and mode codes.
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [4:0] MC_TX_SHUTDOWN = 5'h04;
  localparam logic [4:0] MC_OVERRIDE_SHUTDOWN = 5'h05;
  localparam logic [4:0] MC_RESET_TERMINAL = 5'h08;
  localparam logic [4:0] MC_SEL_SHUTDOWN = 5'h14;
  localparam logic [4:0] MC_SEL_OVERRIDE = 5'h15;
  localparam int IRQ_BITS = 3;
  localparam int IRQ_SHUT = 0;
  localparam int IRQ_OVERRIDE = 1;
  localparam int IRQ_RESET = 2;
endpackage

/* File: hw/bsd_ctrl.sv */
// Bus shutdown and shutdown override control for a dual-redundant remote terminal.
// How it works
// - Auto bit leaves plain commands unaffected.
// - Shutdown commands act on inactive bus only.
// - Never shut down the receiving bus.
// - Shut transmitter stays blocked until reactivated.
// - Override, selected override, terminal reset re-enable.
// - Master reset or soft reset re-enable.
// - Auto bit clear: device does shutdown.
// - Auto bit set: selected forms ignored, no status; host inhibits.
// - Plain commands act whatever their data.
// - Tx-only bit picks transmitter or both.
// - Shutdown sets status bits 15-12.
// - Override restores transmit and receive.
// - Override clears status bits 15-12.
`timescale 1ns/1ps
`default_nettype none
module bsd_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mode command from the protocol decoder, same clock
  input wire logic mc_valid,
  input wire logic [4:0] mc_code,
  input wire logic mc_on_bus_b,
  // Host inhibit pins, asynchronous
  input wire logic inhibit_tx_bus_a_pin,
  input wire logic inhibit_tx_bus_b_pin,
  // Transceiver enables
  output logic tx_enable_a,
  output logic tx_enable_b,
  output logic rx_enable_a,
  output logic rx_enable_b,
  // Interrupt
  output logic irq
);
  // ==========================================================================
  // Register state.
  logic [15:0] config_reg, next_config_reg;
  logic [3:0] shut, next_shut;
  logic [2:0] irq_status, next_irq_status;
  logic [2:0] irq_enable, next_irq_enable;
  logic [31:0] next_prdata;
  logic [2:0] sync_a, sync_b;
  logic pin_a, pin_b, next_pin_a, next_pin_b;

  logic wr, rd, terminal_soft_reset;
  logic [2:0] events;
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign terminal_soft_reset = wr && paddr == bsd_pkg::ADDR_RESET && pwdata[bsd_pkg::RST_TERMINAL];
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ==========================================================================
  // Pin synchronisers: a change counts once stages two and three agree.
  always_comb begin
    next_pin_a = (sync_a[1] == sync_a[2]) ? sync_a[2] : pin_a;
    next_pin_b = (sync_b[1] == sync_b[2]) ? sync_b[2] : pin_b;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      pin_a <= 1'b0;
      pin_b <= 1'b0;
    end else begin
      sync_a <= {sync_a[1:0], inhibit_tx_bus_a_pin};
      sync_b <= {sync_b[1:0], inhibit_tx_bus_b_pin};
      pin_a <= next_pin_a;
      pin_b <= next_pin_b;
    end
  end

  // ==========================================================================
  // Mode command handling. Selected forms skip bus-select matching here.
  always_comb begin
    logic shut_cmd, ovr_cmd, tx_only;
    shut_cmd = 1'b0;
    ovr_cmd = 1'b0;
    tx_only = config_reg[bsd_pkg::CFG_TX_ONLY];
    next_shut = shut;
    events = 3'h0;
    if (mc_valid) begin
      shut_cmd = mc_code == bsd_pkg::MC_TX_SHUTDOWN;
      ovr_cmd = mc_code == bsd_pkg::MC_OVERRIDE_SHUTDOWN;
      // auto bit gates only selected forms
      if (!config_reg[bsd_pkg::CFG_AUTO_DISABLE]) begin
        shut_cmd = shut_cmd | (mc_code == bsd_pkg::MC_SEL_SHUTDOWN);
        ovr_cmd = ovr_cmd | (mc_code == bsd_pkg::MC_SEL_OVERRIDE);
      end
    end
    if (shut_cmd) begin
      events[bsd_pkg::IRQ_SHUT] = 1'b1;
      if (mc_on_bus_b) begin
        next_shut[1:0] = {1'b1, ~tx_only};
      end else begin
        next_shut[3:2] = {1'b1, ~tx_only};
      end
    end
    if (ovr_cmd) begin
      events[bsd_pkg::IRQ_OVERRIDE] = 1'b1;
      if (mc_on_bus_b) begin
        next_shut[1:0] = 2'h0;
      end else begin
        next_shut[3:2] = 2'h0;
      end
    end
    if ((mc_valid && mc_code == bsd_pkg::MC_RESET_TERMINAL) || terminal_soft_reset) begin
      events[bsd_pkg::IRQ_RESET] = 1'b1;
      next_shut = 4'h0;
    end
  end

  // ==========================================================================
  // Register file and interrupt status; a new event wins over a clear.
  always_comb begin
    next_config_reg = config_reg;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    next_prdata = prdata;
    if (wr && paddr == bsd_pkg::ADDR_CONFIG) begin
      next_config_reg = pwdata[15:0];
    end
    if (wr && paddr == bsd_pkg::ADDR_IRQ_ENABLE) begin
      next_irq_enable = pwdata[2:0];
    end
    if (wr && paddr == bsd_pkg::ADDR_IRQ_CLEAR) begin
      next_irq_status = irq_status & ~pwdata[2:0];
    end
    next_irq_status = next_irq_status | events;
    if (rd) begin
      case (paddr)
        bsd_pkg::ADDR_CONFIG: next_prdata = {16'h0000, config_reg};
        // BIT word bits 15-12 report bus shutdown status.
        bsd_pkg::ADDR_BIT_WORD: next_prdata = {16'h0000, shut, 12'h000};
        bsd_pkg::ADDR_IRQ_STATUS: next_prdata = {29'h0, irq_status};
        bsd_pkg::ADDR_IRQ_ENABLE: next_prdata = {29'h0, irq_enable};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= bsd_pkg::CONFIG_RESET;
      shut <= 4'h0;
      irq_status <= 3'h0;
      irq_enable <= 3'h0;
      prdata <= 32'h0000_0000;
    end else begin
      config_reg <= next_config_reg;
      shut <= next_shut;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      prdata <= next_prdata;
    end
  end

  // ==========================================================================
  // Transceiver enables; host inhibits apply in every mode.
  // shut transmitter blocked
  always_comb begin
    tx_enable_b = ~shut[3] & ~config_reg[bsd_pkg::CFG_INHIBIT_TX_B] & ~pin_b;
    rx_enable_b = ~shut[2];
    tx_enable_a = ~shut[1] & ~config_reg[bsd_pkg::CFG_INHIBIT_TX_A] & ~pin_a;
    rx_enable_a = ~shut[0];
    irq = |(irq_status & irq_enable);
  end
endmodule // bsd_ctrl
`default_nettype wire

/* File: tb/bsd_bc_model.sv */
// Bus controller model that issues mode commands on either bus.
`timescale 1ns/1ps
`default_nettype none
module bsd_bc_model (
  // Clock
  input wire logic pclk,
  // Mode command
  output logic mc_valid,
  output logic [4:0] mc_code,
  output logic mc_on_bus_b
);
  initial begin
    mc_valid = 1'b0;
    mc_code = 5'h1F;
    mc_on_bus_b = 1'b0;
  end
  // Code and bus are scrambled once the pulse ends, so a stale field never looks valid.
  task automatic send(input logic [4:0] code, input logic on_b);
    mc_valid <= 1'b1;
    mc_code <= code;
    mc_on_bus_b <= on_b;
    @(posedge pclk);
    mc_valid <= 1'b0;
    mc_code <= ~code;
    mc_on_bus_b <= ~on_b;
    @(posedge pclk);
  endtask
endmodule // bsd_bc_model
`default_nettype wire

/* File: tb/bsd_ctrl_properties.sv */
// Concurrent checks on the bus shutdown control ports.
`timescale 1ns/1ps
`default_nettype none
module bsd_ctrl_properties (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // Mode command and enables
  input wire logic mc_valid,
  input wire logic [4:0] mc_code,
  input wire logic mc_on_bus_b,
  input wire logic tx_enable_a,
  input wire logic tx_enable_b,
  input wire logic rx_enable_a,
  input wire logic rx_enable_b
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic sd;
  logic wr;
  assign sd = mc_valid && mc_code == bsd_pkg::MC_TX_SHUTDOWN;
  assign wr = psel && pwrite;
  property p_zero_wait; psel && penable |-> pready && !pslverr; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access not answered");
  property p_shut_b; sd && !mc_on_bus_b |=> !tx_enable_b; endproperty
  a_shut_b: assert property (p_shut_b) else $error("bus b not shut");
  property p_shut_a; sd && mc_on_bus_b |=> !tx_enable_a; endproperty
  a_shut_a: assert property (p_shut_a) else $error("bus a not shut");
  property p_own_a; sd && !mc_on_bus_b && !wr |=> rx_enable_a == $past(rx_enable_a); endproperty
  a_own_a: assert property (p_own_a) else $error("own bus a touched");
  property p_own_b; sd && mc_on_bus_b && !wr |=> rx_enable_b == $past(rx_enable_b); endproperty
  a_own_b: assert property (p_own_b) else $error("own bus b touched");
  property p_override; mc_valid && mc_code == bsd_pkg::MC_OVERRIDE_SHUTDOWN && !mc_on_bus_b |=> rx_enable_b; endproperty
  a_override: assert property (p_override) else $error("override failed");
  property p_term; mc_valid && mc_code == bsd_pkg::MC_RESET_TERMINAL |=> rx_enable_a && rx_enable_b; endproperty
  a_term: assert property (p_term) else $error("terminal reset failed");
  property p_hold; !rx_enable_b && !mc_valid && !wr |=> !rx_enable_b; endproperty
  a_hold: assert property (p_hold) else $error("shut bus reopened");
  property p_quiet; rx_enable_a && !mc_valid && !wr |=> rx_enable_a; endproperty
  a_quiet: assert property (p_quiet) else $error("bus a shut unasked");
  c_shut: cover property (sd);
  c_reopen: cover property (!rx_enable_b ##1 rx_enable_b);
  c_tx_only: cover property (!tx_enable_a && rx_enable_a);
endmodule // bsd_ctrl_properties
bind bsd_ctrl bsd_ctrl_properties i_bsd_ctrl_properties (.*);
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the bus shutdown control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pin_a = 1'b0, pin_b = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, r;
  logic pready, pslverr, mc_valid, mc_on_bus_b, irq, tx_a, tx_b, rx_a, rx_b;
  logic [4:0] mc_code;
  int num_errors = 0, n_checks = 0;
  always #20 pclk = ~pclk;
  bsd_bc_model i_bsd_bc_model (.pclk(pclk), .mc_valid(mc_valid), .mc_code(mc_code), .mc_on_bus_b(mc_on_bus_b));
  bsd_ctrl i_bsd_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mc_valid(mc_valid),
    .mc_code(mc_code), .mc_on_bus_b(mc_on_bus_b), .inhibit_tx_bus_a_pin(pin_a), .inhibit_tx_bus_b_pin(pin_b),
    .tx_enable_a(tx_a), .tx_enable_b(tx_b), .rx_enable_a(rx_a), .rx_enable_b(rx_b), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(r, e);
  endtask
  task automatic en(input logic [3:0] e);
    chk({27'h0000000, irq, tx_a, tx_b, rx_a, rx_b}, {27'h0000000, e[3:0] != 4'hF, e});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(bsd_pkg::ADDR_CONFIG, 32'h00000000);
    rd(12'h0FC, 32'h00000000);
    apb(1'b1, bsd_pkg::ADDR_IRQ_ENABLE, 32'h00000001);
    en(4'hF);
    i_bsd_bc_model.send(bsd_pkg::MC_TX_SHUTDOWN, 1'b0);
    en(4'hA);
    rd(bsd_pkg::ADDR_BIT_WORD, 32'h0000C000);
    rd(bsd_pkg::ADDR_IRQ_STATUS, 32'h00000001);
    i_bsd_bc_model.send(bsd_pkg::MC_OVERRIDE_SHUTDOWN, 1'b0);
    apb(1'b1, bsd_pkg::ADDR_IRQ_CLEAR, 32'h00000007);
    en(4'hF);
    rd(bsd_pkg::ADDR_BIT_WORD, 32'h00000000);
    apb(1'b1, bsd_pkg::ADDR_IRQ_ENABLE, 32'h00000000);
    apb(1'b1, bsd_pkg::ADDR_CONFIG, 32'h00002000);
    i_bsd_bc_model.send(bsd_pkg::MC_TX_SHUTDOWN, 1'b1);
    chk({tx_a, tx_b, rx_a, rx_b}, 4'h7);
    rd(bsd_pkg::ADDR_BIT_WORD, 32'h00002000);
    apb(1'b1, bsd_pkg::ADDR_RESET, 32'h00000400);
    chk({tx_a, tx_b, rx_a, rx_b}, 4'hF);
    apb(1'b1, bsd_pkg::ADDR_CONFIG, 32'h00002010);
    i_bsd_bc_model.send(bsd_pkg::MC_SEL_SHUTDOWN, 1'b0);
    chk({tx_a, tx_b, rx_a, rx_b}, 4'hF);
    i_bsd_bc_model.send(bsd_pkg::MC_TX_SHUTDOWN, 1'b0);
    chk({tx_a, tx_b, rx_a, rx_b}, 4'hB);
    i_bsd_bc_model.send(bsd_pkg::MC_RESET_TERMINAL, 1'b0);
    chk({tx_a, tx_b, rx_a, rx_b}, 4'hF);
    apb(1'b1, bsd_pkg::ADDR_CONFIG, 32'h00008000);
    chk({tx_a, tx_b, rx_a, rx_b}, 4'h7);
    i_bsd_bc_model.send(bsd_pkg::MC_SEL_SHUTDOWN, 1'b1);
    chk({rx_a, rx_b}, 2'h1);
    i_bsd_bc_model.send(bsd_pkg::MC_SEL_OVERRIDE, 1'b1);
    apb(1'b1, bsd_pkg::ADDR_CONFIG, 32'h00000000);
    pin_b <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({tx_a, tx_b, rx_a, rx_b}, 4'hB);
    i_bsd_bc_model.send(bsd_pkg::MC_TX_SHUTDOWN, 1'b0);
    chk({rx_a, rx_b}, 2'h2);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({rx_a, rx_b}, 2'h3);
    rd(bsd_pkg::ADDR_BIT_WORD, 32'h00000000);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
